// >>> logic/wdpl_tick.sv
`timescale 1ns/10ps
module wdpl_tick #(
    parameter int MS_CYCLES = wdpl_pkg::MS_CYCLES
) (
    // Clock, reset, enable
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // Control
    input wire logic restart_i,
    input wire wdpl_pkg::wdpl_mode_t mode_i,
    // Ticks and waves
    output logic unit_tick_o,
    output logic led_1hz_o,
    output logic led_q25_o
);

    localparam int MSW = $clog2(MS_CYCLES + 1);

    logic [MSW-1:0] ms_cnt, next_ms_cnt;
    logic [9:0] ms_s, next_ms_s;
    logic [5:0] s_min, next_s_min;
    logic [5:0] ms_fm, next_ms_fm;
    logic [8:0] led_ms, next_led_ms;
    logic [1:0] led_half, next_led_half;
    logic next_led_1hz, next_led_q25;
    logic ms_tick, s_tick, min_tick, fm_tick, half_tick;

    ////////////////////////////////////////////////////////////////////////
    // Unit prescalers, restarted on load; LED waves run free
    always_comb begin
        ms_tick = ms_cnt == MSW'(MS_CYCLES - 1);
        s_tick = ms_tick && ms_s == 10'(wdpl_pkg::MS_PER_S - 1);
        min_tick = s_tick && s_min == 6'(wdpl_pkg::S_PER_MIN - 1);
        fm_tick = ms_tick && ms_fm == 6'(wdpl_pkg::MS_PER_FAST_MIN - 1);
        half_tick = ms_tick && led_ms == 9'(wdpl_pkg::MS_PER_LED_HALF - 1);
        next_ms_cnt = ms_tick ? '0 : ms_cnt + 1'b1;
        next_ms_s = ms_s;
        next_s_min = s_min;
        next_ms_fm = ms_fm;
        next_led_ms = led_ms;
        next_led_half = led_half;
        next_led_1hz = led_1hz_o;
        next_led_q25 = led_q25_o;
        if (ms_tick) begin
            next_ms_s = s_tick ? '0 : ms_s + 1'b1;
            next_ms_fm = fm_tick ? '0 : ms_fm + 1'b1;
            next_led_ms = half_tick ? '0 : led_ms + 1'b1;
        end
        if (s_tick) begin
            next_s_min = min_tick ? '0 : s_min + 1'b1;
        end
        if (half_tick) begin
            next_led_1hz = !led_1hz_o;
            next_led_half = led_half + 1'b1;
            if (led_half == 2'(wdpl_pkg::HALVES_PER_Q25_TOGGLE - 1)) begin
                next_led_q25 = !led_q25_o;
            end
        end
        if (restart_i) begin
            next_ms_cnt = '0;
            next_ms_s = '0;
            next_s_min = '0;
            next_ms_fm = '0;
        end
        case ({mode_i.fast, mode_i.minute})
            2'h0: unit_tick_o = s_tick;
            2'h1: unit_tick_o = min_tick;
            2'h2: unit_tick_o = ms_tick;
            2'h3: unit_tick_o = fm_tick;
            default: unit_tick_o = 1'b0;
        endcase
        if (restart_i) begin
            unit_tick_o = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ms_cnt <= '0;
            ms_s <= '0;
            s_min <= '0;
            ms_fm <= '0;
            led_ms <= '0;
            led_half <= '0;
            led_1hz_o <= 1'b0;
            led_q25_o <= 1'b0;
        end else if (ce_i) begin
            ms_cnt <= next_ms_cnt;
            ms_s <= next_ms_s;
            s_min <= next_s_min;
            ms_fm <= next_ms_fm;
            led_ms <= next_led_ms;
            led_half <= next_led_half;
            led_1hz_o <= next_led_1hz;
            led_q25_o <= next_led_q25;
        end
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_b_i);

    fast_sec_unit_a: assert property (
        mode_i.fast && !mode_i.minute && !restart_i |-> unit_tick_o == ms_tick)
        else $error("fast second unit is not one millisecond");
    min_unit_a: assert property (
        !mode_i.fast && mode_i.minute && unit_tick_o |-> s_tick)
        else $error("minute unit tick off a second boundary");

endmodule

// >>> logic/wdpl_top.sv
// Notes on behaviour
// - Activate bit low keeps timeout and LED inactive
// - LED mode: high, low, 1 Hz, 0.25 Hz
// - Fast bit divides time unit by thousand
// - Unit bit picks seconds or minutes
// - Enabled keyboard-controller reset rising edge forces timeout
// - Enabled: timeout pulses keyboard reset low
// - Non-zero counter write loads and starts counting
// - Enabled mouse/keyboard interrupts reload last non-zero value
// - Counter read returns live count
// - Zero disables timeout; N expires after N units
// - Status sets on timeout; software writes zero
// - Trigger bit forces timeout, self-clearing
`timescale 1ns/10ps
module wdpl_top #(
    parameter int MS_CYCLES = wdpl_pkg::MS_CYCLES
) (
    // Clock, reset, enable
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // Register port
    input wire wdpl_pkg::wdpl_bus_req_t bus_i,
    output logic [7:0] rdata_o,
    // Event inputs
    input wire logic kbd_irq_i,
    input wire logic mouse_irq_i,
    input wire logic kbc_reset_port_bit_i,
    // Outputs
    output logic watchdog_timeout_out_n_o,
    output logic keyboard_reset_out_n_o,
    output logic power_indicator_out_o
);

    function automatic logic wr_hit(input wdpl_pkg::wdpl_bus_req_t r,
                                    input logic [7:0] a);
        return r.wr && r.addr == a;
    endfunction

    logic act, next_act;
    wdpl_pkg::wdpl_mode_t mode, next_mode;
    logic [3:0] irq_sel, next_irq_sel;
    logic mouse_rld, next_mouse_rld;
    logic kbd_rld, next_kbd_rld;
    logic [7:0] count, next_count;
    logic [7:0] reload, next_reload;
    logic status, next_status;
    wdpl_pkg::wdpl_state_t state, next_state;
    logic [3:0] kb_cnt, next_kb_cnt;
    logic prev_kbc, prev_kbd, prev_mouse;
    logic [7:0] next_rdata;
    logic next_watchdog_timeout_out_n_n, next_keyboard_reset_out_n_n, next_led;
    logic w_act, w_mode, w_cnt, w_stat;
    logic kbc_rise, kbd_rise, mouse_rise;
    logic trig, kbc_ev, reload_ev, expire, timeout_ev, restart;
    logic unit_tick, led_1hz, led_q25;

    ////////////////////////////////////////////////////////////////////////
    // Time base
    wdpl_tick #(
        .MS_CYCLES(MS_CYCLES)
    ) u_tick (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .restart_i(restart),
        .mode_i(mode),
        .unit_tick_o(unit_tick),
        .led_1hz_o(led_1hz),
        .led_q25_o(led_q25)
    );

    ////////////////////////////////////////////////////////////////////////
    // Registers, counter and events
    always_comb begin
        w_act = wr_hit(bus_i, wdpl_pkg::ADDR_ACTIVATE);
        w_mode = wr_hit(bus_i, wdpl_pkg::ADDR_CTRL_MODE);
        w_cnt = wr_hit(bus_i, wdpl_pkg::ADDR_COUNTER);
        w_stat = wr_hit(bus_i, wdpl_pkg::ADDR_CTRL_STAT);
        kbc_rise = kbc_reset_port_bit_i && !prev_kbc;
        kbd_rise = kbd_irq_i && !prev_kbd;
        mouse_rise = mouse_irq_i && !prev_mouse;

        next_act = act;
        next_mode = mode;
        next_irq_sel = irq_sel;
        next_mouse_rld = mouse_rld;
        next_kbd_rld = kbd_rld;
        if (w_act) begin
            next_act = bus_i.wdata[wdpl_pkg::ACT_BIT];
        end
        if (w_mode) begin
            next_mode.led_mode = wdpl_pkg::wdpl_led_mode_t'(
                bus_i.wdata[wdpl_pkg::LED_MODE_LSB +: 2]);
            next_mode.fast = bus_i.wdata[wdpl_pkg::FAST_BIT];
            next_mode.minute = bus_i.wdata[wdpl_pkg::MINUTE_BIT];
            next_mode.kbc_ev_en = bus_i.wdata[wdpl_pkg::KBC_EV_BIT];
            next_mode.keyboard_reset_out_n_en = bus_i.wdata[wdpl_pkg::KEYBOARD_RESET_OUT_N_EN_BIT];
        end
        if (w_stat) begin
            next_mouse_rld = bus_i.wdata[wdpl_pkg::MOUSE_RLD_BIT];
            next_kbd_rld = bus_i.wdata[wdpl_pkg::KBD_RLD_BIT];
            next_irq_sel = bus_i.wdata[wdpl_pkg::IRQ_SEL_LSB +: 4];
        end

        trig = act && w_stat && bus_i.wdata[wdpl_pkg::TRIG_BIT];
        kbc_ev = act && mode.kbc_ev_en && kbc_rise;
        reload_ev = act && reload != 8'h00 &&
            ((mouse_rld && mouse_rise) || (kbd_rld && kbd_rise));
        expire = 1'b0;
        restart = w_cnt || reload_ev;

        next_count = count;
        next_reload = reload;
        next_state = state;
        if (w_cnt) begin
            next_count = bus_i.wdata;
            if (bus_i.wdata != 8'h00) begin
                next_reload = bus_i.wdata;
                next_state = wdpl_pkg::ST_RUN;
            end else begin
                next_state = wdpl_pkg::ST_IDLE;
            end
        end else if (reload_ev) begin
            next_count = reload;
            next_state = wdpl_pkg::ST_RUN;
        end else begin
            case (state)
                wdpl_pkg::ST_RUN: begin
                    if (act && unit_tick) begin
                        next_count = count - 8'h01;
                        if (count == 8'h01) begin
                            expire = 1'b1;
                            next_state = wdpl_pkg::ST_EXPIRED;
                        end
                    end
                end
                wdpl_pkg::ST_IDLE, wdpl_pkg::ST_EXPIRED: begin
                    next_state = state;
                end
                default: begin
                    next_state = wdpl_pkg::ST_IDLE;
                end
            endcase
        end

        timeout_ev = trig || kbc_ev || expire;
        // A timeout in the same cycle as a clear keeps the flag set
        next_status = status;
        if (w_stat && !bus_i.wdata[wdpl_pkg::STATUS_BIT]) begin
            next_status = 1'b0;
        end
        if (timeout_ev) begin
            next_status = 1'b1;
        end

        next_kb_cnt = kb_cnt;
        if (timeout_ev && mode.keyboard_reset_out_n_en) begin
            next_kb_cnt = 4'(wdpl_pkg::KEYBOARD_RESET_OUT_N_PULSE_CYC);
        end else if (kb_cnt != 4'h0) begin
            next_kb_cnt = kb_cnt - 4'h1;
        end

        next_watchdog_timeout_out_n_n = !(next_act && next_status);
        next_keyboard_reset_out_n_n = !(next_act && next_kb_cnt != 4'h0);
        case (next_mode.led_mode)
            wdpl_pkg::LED_HIGH: next_led = 1'b1;
            wdpl_pkg::LED_LOW: next_led = 1'b0;
            wdpl_pkg::LED_1HZ: next_led = led_1hz;
            wdpl_pkg::LED_Q25HZ: next_led = led_q25;
            default: next_led = 1'b0;
        endcase
        if (!next_act) begin
            next_led = 1'b0;
        end

        next_rdata = 8'h00;
        if (bus_i.rd) begin
            case (bus_i.addr)
                wdpl_pkg::ADDR_ACTIVATE: next_rdata = {7'h00, act};
                wdpl_pkg::ADDR_CTRL_MODE: next_rdata = {mode.led_mode, 1'b0,
                    mode.fast, mode.minute, mode.kbc_ev_en,
                    mode.keyboard_reset_out_n_en, 1'b0};
                wdpl_pkg::ADDR_COUNTER: next_rdata = count;
                wdpl_pkg::ADDR_CTRL_STAT: next_rdata = {mouse_rld, kbd_rld,
                    1'b0, status, irq_sel};
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            act <= wdpl_pkg::RST_ACTIVATE[wdpl_pkg::ACT_BIT];
            mode <= '0;
            irq_sel <= wdpl_pkg::RST_CTRL_STAT[3:0];
            mouse_rld <= 1'b0;
            kbd_rld <= 1'b0;
            count <= wdpl_pkg::RST_COUNTER;
            reload <= wdpl_pkg::RST_COUNTER;
            status <= 1'b0;
            state <= wdpl_pkg::ST_IDLE;
            kb_cnt <= 4'h0;
            prev_kbc <= 1'b0;
            prev_kbd <= 1'b0;
            prev_mouse <= 1'b0;
            rdata_o <= 8'h00;
            watchdog_timeout_out_n_o <= 1'b1;
            keyboard_reset_out_n_o <= 1'b1;
            power_indicator_out_o <= 1'b0;
        end else if (ce_i) begin
            act <= next_act;
            mode <= next_mode;
            irq_sel <= next_irq_sel;
            mouse_rld <= next_mouse_rld;
            kbd_rld <= next_kbd_rld;
            count <= next_count;
            reload <= next_reload;
            status <= next_status;
            state <= next_state;
            kb_cnt <= next_kb_cnt;
            prev_kbc <= kbc_reset_port_bit_i;
            prev_kbd <= kbd_irq_i;
            prev_mouse <= mouse_irq_i;
            rdata_o <= next_rdata;
            watchdog_timeout_out_n_o <= next_watchdog_timeout_out_n_n;
            keyboard_reset_out_n_o <= next_keyboard_reset_out_n_n;
            power_indicator_out_o <= next_led;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_b_i);

    inactive_outs_a: assert property (
        !act |-> watchdog_timeout_out_n_o && keyboard_reset_out_n_o
            && !power_indicator_out_o)
        else $error("outputs active while block is inactive");
    led_steady_a: assert property (
        ce_i && act && mode.led_mode == wdpl_pkg::LED_LOW
            && !w_mode && !w_act |=> !power_indicator_out_o)
        else $error("LED not low in drive-low mode");
    kbc_edge_a: assert property (
        ce_i && act && mode.kbc_ev_en && kbc_reset_port_bit_i && !prev_kbc
            |=> status && !watchdog_timeout_out_n_o)
        else $error("enabled reset edge gave no timeout");
    kbc_off_a: assert property (
        ce_i && !mode.kbc_ev_en && !trig && !expire && !status
            |=> !status)
        else $error("status set without a timeout source");
    keyboard_reset_out_n_pulse_a: assert property (
        ce_i && act && !w_act && timeout_ev && mode.keyboard_reset_out_n_en
            |=> !keyboard_reset_out_n_o)
        else $error("keyboard reset pulse missing");
    keyboard_reset_out_n_quiet_a: assert property (
        ce_i && kb_cnt == 4'h0 && !mode.keyboard_reset_out_n_en |=> keyboard_reset_out_n_o)
        else $error("keyboard reset pulsed while disabled");
    counter_load_a: assert property (
        ce_i && w_cnt && bus_i.wdata != 8'h00
            |=> count == $past(bus_i.wdata) && state == wdpl_pkg::ST_RUN)
        else $error("counter write did not load and start");
    reload_ev_a: assert property (
        ce_i && reload_ev && !w_cnt |=> count == $past(reload))
        else $error("interrupt did not reload the counter");
    live_read_a: assert property (
        ce_i && bus_i.rd && bus_i.addr == wdpl_pkg::ADDR_COUNTER
            |=> rdata_o == $past(count))
        else $error("counter read is not the live count");
    zero_off_a: assert property (
        ce_i && w_cnt && bus_i.wdata == 8'h00
            |=> state == wdpl_pkg::ST_IDLE ##1 !expire)
        else $error("zero load did not disable timeouts");
    status_clr_a: assert property (
        ce_i && w_stat && !bus_i.wdata[wdpl_pkg::STATUS_BIT] && !timeout_ev
            |=> !status)
        else $error("status did not clear on write of zero");
    trig_a: assert property (
        ce_i && act && w_stat && bus_i.wdata[wdpl_pkg::TRIG_BIT]
            |=> status)
        else $error("trigger did not force a timeout");
    trig_read_a: assert property (
        bus_i.rd && ce_i |=> !rdata_o[wdpl_pkg::TRIG_BIT])
        else $error("trigger bit reads back as one");
    expire_stop_a: assert property (
        ce_i && state == wdpl_pkg::ST_RUN && act && unit_tick
            && count == 8'h01 && !w_cnt && !reload_ev
            |=> state == wdpl_pkg::ST_EXPIRED && count == 8'h00 && status
            ##1 (count == 8'h00 || $past(restart)))
        else $error("expiry did not flag and stop");

    expire_c: cover property (expire ##1 !watchdog_timeout_out_n_o);
    reload_c: cover property (reload_ev && state == wdpl_pkg::ST_RUN);
    kbc_c: cover property (kbc_ev ##1 !keyboard_reset_out_n_o);
    led_c: cover property ($rose(led_1hz) && act);

endmodule

// >>> shared/wdpl_pkg.sv
package wdpl_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets and reset values
    localparam logic [7:0] ADDR_ACTIVATE = 8'h30;
    localparam logic [7:0] ADDR_CTRL_MODE = 8'hf5;
    localparam logic [7:0] ADDR_COUNTER = 8'hf6;
    localparam logic [7:0] ADDR_CTRL_STAT = 8'hf7;
    localparam logic [7:0] RST_ACTIVATE = 8'h00;
    localparam logic [7:0] RST_CTRL_MODE = 8'h00;
    localparam logic [7:0] RST_COUNTER = 8'h00;
    localparam logic [7:0] RST_CTRL_STAT = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int ACT_BIT = 0;
    localparam int LED_MODE_LSB = 6;
    localparam int FAST_BIT = 4;
    localparam int MINUTE_BIT = 3;
    localparam int KBC_EV_BIT = 2;
    localparam int KEYBOARD_RESET_OUT_N_EN_BIT = 1;
    localparam int MOUSE_RLD_BIT = 7;
    localparam int KBD_RLD_BIT = 6;
    localparam int TRIG_BIT = 5;
    localparam int STATUS_BIT = 4;
    localparam int IRQ_SEL_LSB = 0;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_PS = 8000;
    localparam int MS_PS = 1000000000;
    localparam int MS_CYCLES = MS_PS / CLK_PERIOD_PS;
    localparam int MS_PER_S = 1000;
    localparam int S_PER_MIN = 60;
    localparam int MS_PER_FAST_MIN = 60;
    localparam int MS_PER_LED_HALF = 500;
    localparam int HALVES_PER_Q25_TOGGLE = 4;
    localparam int KEYBOARD_RESET_OUT_N_PULSE_PS = 64000;
    localparam int KEYBOARD_RESET_OUT_N_PULSE_CYC =
        (KEYBOARD_RESET_OUT_N_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        LED_HIGH = 2'h0,
        LED_LOW = 2'h1,
        LED_1HZ = 2'h2,
        LED_Q25HZ = 2'h3
    } wdpl_led_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_RUN = 3'h2,
        ST_EXPIRED = 3'h4
    } wdpl_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } wdpl_bus_req_t;

    typedef struct packed {
        wdpl_led_mode_t led_mode;
        logic fast;
        logic minute;
        logic kbc_ev_en;
        logic keyboard_reset_out_n_en;
    } wdpl_mode_t;

endpackage

// >>> verification/wdpl_bench.sv
`timescale 1ns/10ps
module wdpl_bench;
    localparam int MSC = 4;
    localparam int SEC = MSC * 1000;
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic ce_i = 1'b1;
    wdpl_pkg::wdpl_bus_req_t req = '0;
    logic [2:0] fire = 3'h0;
    logic slow = 1'b0;
    logic [7:0] rdata;
    logic kbd_irq, mouse_irq, kbc_bit, tmo_n, keyboard_reset_out_n_n, led;
    logic [31:0] led_half, keyboard_reset_out_n_width;
    logic [31:0] lfsr = 32'h00016ed9;
    logic [7:0] a_act = wdpl_pkg::ADDR_ACTIVATE;
    logic [7:0] a_mode = wdpl_pkg::ADDR_CTRL_MODE;
    logic [7:0] a_cnt = wdpl_pkg::ADDR_COUNTER;
    logic [7:0] a_stat = wdpl_pkg::ADDR_CTRL_STAT;
    int fails = 0;
    int checked = 0;
    int m_act = 0;
    int m_mode = 0;
    int m_cnt = 0;
    int m_f7 = 0;
    int m_stat = 0;

    always #4 clk_sys_i = ~clk_sys_i;

    wdpl_top #(.MS_CYCLES(MSC)) uut (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .bus_i(req),
        .rdata_o(rdata), .kbd_irq_i(kbd_irq), .mouse_irq_i(mouse_irq),
        .kbc_reset_port_bit_i(kbc_bit), .watchdog_timeout_out_n_o(tmo_n),
        .keyboard_reset_out_n_o(keyboard_reset_out_n_n), .power_indicator_out_o(led));

    wdpl_far_side far (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .fire_i(fire),
        .slow_i(slow), .kbd_irq_o(kbd_irq), .mouse_irq_o(mouse_irq),
        .kbc_bit_o(kbc_bit), .led_i(led), .keyboard_reset_out_n_n_i(keyboard_reset_out_n_n),
        .led_half_o(led_half), .keyboard_reset_out_n_width_o(keyboard_reset_out_n_width));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] next_rand(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    function automatic logic [7:0] expect_rd(input logic [7:0] a);
        case (a)
            wdpl_pkg::ADDR_ACTIVATE: return 8'(m_act);
            wdpl_pkg::ADDR_CTRL_MODE: return 8'(m_mode);
            wdpl_pkg::ADDR_COUNTER: return 8'(m_cnt);
            wdpl_pkg::ADDR_CTRL_STAT: return 8'(m_f7 | (m_stat << 4));
            default: return 8'h00;
        endcase
    endfunction

    task automatic compare(input string what, input logic [31:0] seen,
                           input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys_i);
        req <= '0;
        case (a)
            wdpl_pkg::ADDR_ACTIVATE: m_act = d[0];
            wdpl_pkg::ADDR_CTRL_MODE: m_mode = d & 8'hde;
            wdpl_pkg::ADDR_COUNTER: m_cnt = d;
            wdpl_pkg::ADDR_CTRL_STAT: begin
                m_f7 = d & 8'hcf;
                m_stat = (d[5] && m_act == 1) ? 1 : (d[4] ? m_stat : 0);
            end
            default: ;
        endcase
    endtask

    task automatic rd_chk(input logic [7:0] a);
        @(posedge clk_sys_i);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys_i);
        req <= '0;
        #1;
        compare("read data", 32'(rdata), 32'(expect_rd(a)));
    endtask

    task automatic wait_tmo(input int lo, input int hi, input bit exp_low);
        int n;
        n = 0;
        while (tmo_n !== 1'b0 && n < hi) begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end
        compare("timeout out", 32'(tmo_n), 32'(!exp_low));
        if (exp_low) begin
            compare("timeout delay", 32'(n >= lo), 32'h1);
            m_stat = 1;
        end
    endtask

    task automatic clear_stat(input logic [7:0] f7);
        wr(a_stat, f7);
        @(posedge clk_sys_i);
        #1;
        compare("timeout released", 32'(tmo_n), 32'h1);
    endtask

    task automatic finish_test();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (60000) @(posedge clk_sys_i);
        fails++;
        finish_test();
    end

    initial begin
        logic [7:0] regs [4];
        logic [7:0] v;
        int n;
        int unit;
        regs = '{a_act, a_mode, a_cnt, a_stat};
        repeat (8) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        foreach (regs[i]) rd_chk(regs[i]);
        rd_chk(8'h31);
        // Random contents while inactive: nothing may fire or count
        foreach (regs[i]) begin
            lfsr = next_rand(lfsr);
            wr(regs[i], (i == 0) ? (lfsr[7:0] & 8'hfe) : lfsr[7:0]);
            rd_chk(regs[i]);
        end
        repeat (100) @(posedge clk_sys_i);
        #1;
        compare("inactive timeout", 32'(tmo_n), 32'h1);
        compare("inactive led", 32'(led), 32'h0);
        wr(a_cnt, 8'h00);
        wr(a_stat, 8'h00);
        wr(a_act, 8'h01);
        for (int m = 0; m < 4; m++) begin
            wr(a_mode, 8'(m << 6));
            n = (m == 2) ? SEC / 2 : 2 * SEC;
            repeat ((m < 2) ? 3 : 2 * n + 10) @(posedge clk_sys_i);
            #1;
            if (m < 2) begin
                compare("led level", 32'(led), 32'(m == 0));
            end else begin
                compare("led half", led_half, 32'(n));
            end
        end
        // Fast seconds with pulse, fast minutes, plain seconds
        for (int t = 0; t < 3; t++) begin
            lfsr = next_rand(lfsr);
            v = (t == 0) ? 8'h12 : (t == 1) ? 8'h18 : 8'h00;
            unit = (t == 0) ? SEC / 1000 : (t == 1) ? 60 * SEC / 1000 : SEC;
            n = (t == 0) ? 1 + int'(lfsr[3:0]) : (t == 1) ? 2 : 1;
            wr(a_mode, v);
            wr(a_cnt, 8'(n));
            if (t == 2) begin
                rd_chk(a_cnt);
            end
            wait_tmo(n * unit - 3 * t / 2, n * unit + 4, 1'b1);
            compare("kbd reset", 32'(keyboard_reset_out_n_n), 32'(!v[1]));
            m_cnt = 0;
            repeat (12) @(posedge clk_sys_i);
            rd_chk(a_cnt);
            rd_chk(a_stat);
            compare("timeout held", 32'(tmo_n), 32'h0);
            if (v[1]) begin
                compare("kbd reset width", keyboard_reset_out_n_width, 32'h8);
            end
            clear_stat(8'h00);
        end
        // Plain minutes: one unit outlasts a whole second
        wr(a_mode, 8'h08);
        wr(a_cnt, 8'h01);
        wait_tmo(0, SEC + 8, 1'b0);
        rd_chk(a_cnt);
        wr(a_cnt, 8'h00);
        // Low clock enable freezes the count
        wr(a_mode, 8'h10);
        wr(a_cnt, 8'h02);
        ce_i <= 1'b0;
        repeat (20) @(posedge clk_sys_i);
        ce_i <= 1'b1;
        wait_tmo(8, 12, 1'b1);
        clear_stat(8'h00);
        wr(a_cnt, 8'h05);
        wr(a_cnt, 8'h00);
        wait_tmo(0, 100, 1'b0);
        // Keyboard and mouse interrupts, reload enabled and not
        for (int k = 0; k < 4; k++) begin
            v = k[1] ? (k[0] ? 8'h80 : 8'h40) : 8'h00;
            clear_stat(v);
            wr(a_cnt, 8'd20);
            repeat (60) @(posedge clk_sys_i);
            fire <= k[0] ? 3'h2 : 3'h1;
            slow <= k[0];
            @(posedge clk_sys_i);
            fire <= 3'h0;
            wait_tmo(k[1] ? 80 : 0, k[1] ? 88 : 30, 1'b1);
        end
        clear_stat(8'h00);
        wr(a_stat, 8'h20);
        wait_tmo(0, 3, 1'b1);
        rd_chk(a_stat);
        for (int e = 0; e < 2; e++) begin
            clear_stat(8'h00);
            wr(a_mode, e[0] ? 8'h06 : 8'h00);
            fire <= 3'h4;
            slow <= 1'b0;
            @(posedge clk_sys_i);
            fire <= 3'h0;
            wait_tmo(0, 6, e[0]);
            compare("kbd reset", 32'(keyboard_reset_out_n_n), 32'(!e[0]));
        end
        // Reset in mid-run drops every output and register
        @(posedge clk_sys_i);
        rst_b_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        m_act = 0;
        m_mode = 0;
        m_cnt = 0;
        m_f7 = 0;
        m_stat = 0;
        foreach (regs[i]) rd_chk(regs[i]);
        compare("reset outs", 32'({tmo_n, keyboard_reset_out_n_n, led}), 32'h6);
        finish_test();
    end
endmodule

// >>> verification/wdpl_far_side.sv
`timescale 1ns/10ps
module wdpl_far_side (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // Bench commands: bit 0 keyboard, bit 1 mouse, bit 2 reset port bit
    input wire logic [2:0] fire_i,
    input wire logic slow_i,
    // Lines into the block
    output logic kbd_irq_o,
    output logic mouse_irq_o,
    output logic kbc_bit_o,
    // Block outputs watched here
    input wire logic led_i,
    input wire logic keyboard_reset_out_n_n_i,
    output logic [31:0] led_half_o,
    output logic [31:0] keyboard_reset_out_n_width_o
);
    int hold [3];
    int led_cnt;
    int low_cnt;
    logic led_q;

    ////////////////////////////////////////////////////////////////////////
    // Event lines stay high 2 cycles, or 20 when slow
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hold <= '{0, 0, 0};
        end else begin
            for (int k = 0; k < 3; k++) begin
                if (fire_i[k]) begin
                    hold[k] <= slow_i ? 20 : 2;
                end else if (hold[k] > 0) begin
                    hold[k] <= hold[k] - 1;
                end
            end
        end
    end
    assign kbd_irq_o = hold[0] > 0;
    assign mouse_irq_o = hold[1] > 0;
    assign kbc_bit_o = hold[2] > 0;

    ////////////////////////////////////////////////////////////////////////
    // Cycles between LED edges and length of each keyboard reset pulse
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            led_q <= 1'b0;
            led_cnt <= 0;
            low_cnt <= 0;
            led_half_o <= 32'h0;
            keyboard_reset_out_n_width_o <= 32'h0;
        end else begin
            led_q <= led_i;
            led_cnt <= (led_i !== led_q) ? 1 : led_cnt + 1;
            if (led_i !== led_q) begin
                led_half_o <= 32'(led_cnt);
            end
            low_cnt <= (keyboard_reset_out_n_n_i === 1'b0) ? low_cnt + 1 : 0;
            if (keyboard_reset_out_n_n_i !== 1'b0 && low_cnt > 0) begin
                keyboard_reset_out_n_width_o <= 32'(low_cnt);
            end
        end
    end
endmodule
